// ---- include/crrp_cfg.svh ----
`ifndef CRRP_CFG_SVH
`define CRRP_CFG_SVH

// slave address layout
`define CRRP_ID_MSB 7
`define CRRP_ID_LSB 4
`define CRRP_SEL_MSB 2
`define CRRP_SEL_LSB 1
`define CRRP_RW_BIT 0

// slave identifiers of the two logical devices
`define CRRP_ID_REG 4'hd
`define CRRP_ID_MEM 4'ha

// register space
`define CRRP_REG_AW 5
`define CRRP_REG_MAX 5'h18
`define CRRP_REG_RST 5'h00

// memory pointer default width (largest family member)
`define CRRP_MEM_AW 15

// byte framing
`define CRRP_BIT_LAST 3'h7
`define CRRP_BYTE_ADDR 2'h0
`define CRRP_BYTE_ADDR2 2'h1
`define CRRP_BYTE_DATA 2'h2

`endif

// ---- include/crrp_pkg.sv ----
package crrp_pkg;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK  = 7'h04,
      ST_ACKH = 7'h08,
      ST_RX   = 7'h10,
      ST_TX   = 7'h20,
      ST_TXAK = 7'h40
   } crrp_state_t;

endpackage

// ---- core/crrp_sync.sv ----
module crrp_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // the first stage is read by the second stage only
   always_ff @(posedge core_clk or negedge rst_n) begin
      // reset to the idle level of the two-wire lines, so no false edge
      // is seen when reset lets go
      if (!rst_n) begin
         meta_q <= '1;
         q <= '1;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// ---- core/crrp_slave.sv ----
`include "crrp_cfg.svh"
// How it works
// - after a matching read address the first data bit goes out on the falling edge that ends the acknowledge clock.
// - the register pointer steps by one after every register byte moves, so reads run through consecutive registers.
// - a current-address register read walks the same states as a memory read; only the identifier differs.
// - memory and register pointers are separate and loading or stepping one never touches the other.
// - register traffic leaves the memory pointer alone, so a later memory read resumes where it stopped.
// - slave address bits 7-4 pick registers or memory, and register transfers never reach memory.
// - a register address whose low five bits exceed the top register is refused with a not-acknowledge and the transfer is dropped.
// - after each read byte the bus is released for the acknowledge; acknowledge sends more, not-acknowledge ends.
// - the device answers only when address bits 2-1 match its two select pins.
module crrp_slave #(
   parameter int MEM_AW = `CRRP_MEM_AW
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic [1:0] dev_sel,
   output logic [`CRRP_REG_AW-1:0] reg_ptr,
   input wire logic [7:0] reg_rdata,
   output logic reg_rd,
   output logic reg_wr,
   output logic [MEM_AW-1:0] mem_ptr,
   input wire logic [7:0] mem_rdata,
   output logic mem_rd,
   output logic mem_wr,
   output logic [MEM_AW-1:0] wr_addr,
   output logic [7:0] wr_data
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] rst_q;
   logic rst_n;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   logic [3:0] pins_s;
   logic scl_s, sda_s, scl_p, sda_p;
   logic [1:0] sel_s;

   crrp_sync #(.W(4)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .d({scl_i, sda_i, dev_sel}),
      .q(pins_s)
   );
   assign {scl_s, sda_s, sel_s} = pins_s;

   // idle bus is high, so reset the history high to avoid a false start
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_p <= scl_s;
         sda_p <= sda_s;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
   assign bus_stop = scl_s & scl_p & ~sda_p & sda_s;

   // register pointer wraps after the top register
   function automatic logic [`CRRP_REG_AW-1:0] next_reg(
      input logic [`CRRP_REG_AW-1:0] p);
      next_reg = (p == `CRRP_REG_MAX) ? `CRRP_REG_RST :
         `CRRP_REG_AW'(p + 1'b1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   crrp_pkg::crrp_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d, byte_in;
   logic [2:0] cnt_q, cnt_d;
   logic [1:0] nbyte_q, nbyte_d;
   logic is_reg_q, is_reg_d, is_rd_q, is_rd_d, oe_q, oe_d;
   logic [7:0] hi_q, hi_d, wdat_q, wdat_d, load;
   logic [`CRRP_REG_AW-1:0] rptr_q, rptr_d;
   logic [MEM_AW-1:0] mptr_q, mptr_d, waddr_q, waddr_d;
   logic rrd_q, rrd_d, mrd_q, mrd_d, rwr_q, rwr_d, mwr_q, mwr_d;

   assign byte_in = {sh_q[6:0], sda_s};
   assign load = is_reg_q ? reg_rdata : mem_rdata;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      nbyte_d = nbyte_q;
      is_reg_d = is_reg_q;
      is_rd_d = is_rd_q;
      oe_d = oe_q;
      hi_d = hi_q;
      wdat_d = wdat_q;
      waddr_d = waddr_q;
      rptr_d = rptr_q;
      mptr_d = mptr_q;
      rrd_d = 1'b0;
      mrd_d = 1'b0;
      rwr_d = 1'b0;
      mwr_d = 1'b0;
      if (bus_start) begin
         st_d = crrp_pkg::ST_ADDR;
         cnt_d = 3'h0;
         oe_d = 1'b0;
      end else if (bus_stop) begin
         st_d = crrp_pkg::ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            crrp_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  sh_d = byte_in;
                  cnt_d = 3'(cnt_q + 1'b1);
                  if (cnt_q == `CRRP_BIT_LAST) begin
                     if ((byte_in[`CRRP_ID_MSB:`CRRP_ID_LSB] == `CRRP_ID_REG ||
                        byte_in[`CRRP_ID_MSB:`CRRP_ID_LSB] == `CRRP_ID_MEM) &&
                        byte_in[`CRRP_SEL_MSB:`CRRP_SEL_LSB] == sel_s) begin
                        st_d = crrp_pkg::ST_ACK;
                        is_reg_d = byte_in[`CRRP_ID_MSB:`CRRP_ID_LSB] ==
                           `CRRP_ID_REG;
                        is_rd_d = byte_in[`CRRP_RW_BIT];
                        nbyte_d = `CRRP_BYTE_ADDR;
                     end else begin
                        st_d = crrp_pkg::ST_IDLE;
                     end
                  end
               end
            end
            crrp_pkg::ST_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b1;
                  st_d = crrp_pkg::ST_ACKH;
               end
            end
            crrp_pkg::ST_ACKH: begin
               if (scl_fall) begin
                  cnt_d = 3'h0;
                  if (is_rd_q) begin
                     // read starts from the current pointer
                     sh_d = load;
                     oe_d = ~load[7];
                     rrd_d = is_reg_q;
                     mrd_d = ~is_reg_q;
                     st_d = crrp_pkg::ST_TX;
                  end else begin
                     oe_d = 1'b0;
                     st_d = crrp_pkg::ST_RX;
                  end
               end
            end
            crrp_pkg::ST_RX: begin
               if (scl_rise) begin
                  sh_d = byte_in;
                  cnt_d = 3'(cnt_q + 1'b1);
                  if (cnt_q == `CRRP_BIT_LAST) begin
                     st_d = crrp_pkg::ST_ACK;
                     if (nbyte_q != `CRRP_BYTE_DATA) begin
                        nbyte_d = 2'(nbyte_q + 1'b1);
                     end
                     if (is_reg_q) begin
                        // first byte is always the address
                        if (nbyte_q == `CRRP_BYTE_ADDR) begin
                           if (byte_in[`CRRP_REG_AW-1:0] > `CRRP_REG_MAX) begin
                              st_d = crrp_pkg::ST_IDLE;
                           end else begin
                              rptr_d = byte_in[`CRRP_REG_AW-1:0];
                              nbyte_d = `CRRP_BYTE_DATA;
                           end
                        end else begin
                           rwr_d = 1'b1;
                           wdat_d = byte_in;
                           waddr_d = MEM_AW'(rptr_q);
                           rptr_d = next_reg(rptr_q);
                        end
                     end else if (nbyte_q == `CRRP_BYTE_ADDR) begin
                        hi_d = byte_in;
                     end else if (nbyte_q == `CRRP_BYTE_ADDR2) begin
                        mptr_d = MEM_AW'({hi_q, byte_in});
                     end else begin
                        mwr_d = 1'b1;
                        wdat_d = byte_in;
                        waddr_d = mptr_q;
                        mptr_d = MEM_AW'(mptr_q + 1'b1);
                     end
                  end
               end
            end
            crrp_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (cnt_q == `CRRP_BIT_LAST) begin
                     oe_d = 1'b0;
                     st_d = crrp_pkg::ST_TXAK;
                     // only the pointer of this space moves
                     if (is_reg_q) begin
                        rptr_d = next_reg(rptr_q);
                     end else begin
                        mptr_d = MEM_AW'(mptr_q + 1'b1);
                     end
                  end else begin
                     oe_d = ~sh_q[6];
                     sh_d = {sh_q[6:0], 1'b0};
                     cnt_d = 3'(cnt_q + 1'b1);
                  end
               end
            end
            crrp_pkg::ST_TXAK: begin
               // acknowledged: reuse the hold state to send the next byte
               if (scl_rise) begin
                  st_d = sda_s ? crrp_pkg::ST_IDLE : crrp_pkg::ST_ACKH;
               end
            end
            default: begin
               st_d = crrp_pkg::ST_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= crrp_pkg::ST_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
         nbyte_q <= `CRRP_BYTE_ADDR;
         is_reg_q <= 1'b0;
         is_rd_q <= 1'b0;
         oe_q <= 1'b0;
         hi_q <= 8'h00;
         wdat_q <= 8'h00;
         waddr_q <= '0;
         rptr_q <= `CRRP_REG_RST;
         mptr_q <= '0;
         rrd_q <= 1'b0;
         mrd_q <= 1'b0;
         rwr_q <= 1'b0;
         mwr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         nbyte_q <= nbyte_d;
         is_reg_q <= is_reg_d;
         is_rd_q <= is_rd_d;
         oe_q <= oe_d;
         hi_q <= hi_d;
         wdat_q <= wdat_d;
         waddr_q <= waddr_d;
         rptr_q <= rptr_d;
         mptr_q <= mptr_d;
         rrd_q <= rrd_d;
         mrd_q <= mrd_d;
         rwr_q <= rwr_d;
         mwr_q <= mwr_d;
      end
   end

   // open drain: the pad only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = oe_q;
   assign reg_ptr = rptr_q;
   assign mem_ptr = mptr_q;
   assign reg_rd = rrd_q;
   assign mem_rd = mrd_q;
   assign reg_wr = rwr_q;
   assign mem_wr = mwr_q;
   assign wr_addr = waddr_q;
   assign wr_data = wdat_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_last_tx_bit;
      st_q == crrp_pkg::ST_TX && scl_fall && cnt_q == `CRRP_BIT_LAST &&
         !bus_start && !bus_stop;
   endsequence

   sequence s_read_go;
      st_q == crrp_pkg::ST_ACKH && is_rd_q && scl_fall &&
         !bus_start && !bus_stop;
   endsequence

   AST_READ_START: assert property (
      s_read_go |=> st_q == crrp_pkg::ST_TX && (reg_rd ^ mem_rd) &&
         sda_oe == ~sh_q[7])
      else $error("read did not start driving data");
   AST_REG_STEP: assert property (
      s_last_tx_bit ##0 is_reg_q |=> reg_ptr == next_reg($past(reg_ptr)))
      else $error("register pointer did not advance");
   AST_PTR_APART: assert property (
      s_last_tx_bit ##0 is_reg_q |=> mem_ptr == $past(mem_ptr))
      else $error("register read moved memory pointer");
   AST_MEM_KEPT: assert property (
      is_reg_q && st_q != crrp_pkg::ST_ADDR |=> $stable(mem_ptr))
      else $error("memory pointer changed during register transfer");
   AST_NO_MEM_WR: assert property (
      is_reg_q |-> !mem_wr)
      else $error("register transfer wrote memory");
   AST_BAD_REG: assert property (
      st_q == crrp_pkg::ST_RX && scl_rise && cnt_q == `CRRP_BIT_LAST &&
      is_reg_q && nbyte_q == `CRRP_BYTE_ADDR && !bus_start && !bus_stop &&
      byte_in[`CRRP_REG_AW-1:0] > `CRRP_REG_MAX
      |=> st_q == crrp_pkg::ST_IDLE ##1 !sda_oe [*2])
      else $error("illegal register address acknowledged");
   AST_ACK_RELEASE: assert property (
      s_last_tx_bit |=> !sda_oe throughout
         (st_q == crrp_pkg::ST_TXAK [*1]))
      else $error("bus not released for master acknowledge");
   AST_MASTER_NACK: assert property (
      st_q == crrp_pkg::ST_TXAK && scl_rise && sda_s && !bus_start &&
      !bus_stop |=> st_q == crrp_pkg::ST_IDLE && !sda_oe)
      else $error("read continued after not-acknowledge");
   AST_SEL_MISS: assert property (
      st_q == crrp_pkg::ST_ADDR && scl_rise && cnt_q == `CRRP_BIT_LAST &&
      !bus_start && !bus_stop &&
      byte_in[`CRRP_SEL_MSB:`CRRP_SEL_LSB] != sel_s
      |=> st_q == crrp_pkg::ST_IDLE)
      else $error("answered a foreign select code");

endmodule

// ---- sim/crrp_i2c_master.sv ----
// two-wire bus master: drives scl, pulls sda low through sda_pull
module crrp_i2c_master (
   input wire logic core_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   // quarter bit in core cycles, well above the slave's 3 cycle sync delay
   localparam int QTR = 10;

   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // start and repeated start: sda falls while scl is high
   task automatic start();
      tick(QTR);
      sda_pull = 1'b0;
      tick(QTR);
      scl = 1'b1;
      tick(QTR);
      sda_pull = 1'b1;
      tick(QTR);
      scl = 1'b0;
   endtask

   task automatic stop();
      tick(QTR);
      sda_pull = 1'b1;
      tick(QTR);
      scl = 1'b1;
      tick(QTR);
      sda_pull = 1'b0;
      tick(QTR);
   endtask

   // sda moves only mid-low, never with the scl edge, so no false start
   task automatic xbit(input logic b, output logic r);
      tick(QTR);
      sda_pull = ~b;
      tick(QTR);
      scl = 1'b1;
      tick(QTR);
      r = sda;
      tick(QTR);
      scl = 1'b0;
   endtask

   // eight bits msb first, then the acknowledge bit
   task automatic xbyte(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic sack);
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], q[i]);
      end
      xbit(mack, sack);
   endtask
endmodule

// ---- sim/companion_register_read_pointer_tb.sv ----
module companion_register_read_pointer_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int MAW = 15;
   localparam logic [1:0] SEL = 2'b10;

   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [1:0] dev_sel = SEL;
   logic scl, sda_pull, sda_o, sda_oe, reg_rd, reg_wr, mem_rd, mem_wr;
   logic [4:0] reg_ptr;
   logic [MAW-1:0] mem_ptr, wr_addr;
   logic [7:0] wr_data, reg_rdata, mem_rdata;
   wire logic sda;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int n_rrd = 0;
   int n_mrd = 0;
   int n_rwr = 0;
   int n_mwr = 0;

   // strobe monitor: every one-cycle pulse is counted once
   always @(posedge core_clk) begin
      if (reg_rd === 1'b1) begin
         n_rrd++;
      end
      if (mem_rd === 1'b1) begin
         n_mrd++;
      end
      if (reg_wr === 1'b1) begin
         n_rwr++;
      end
      if (mem_wr === 1'b1) begin
         n_mwr++;
      end
   end

   // open drain with pull-up: released line reads high
   assign sda = ~(sda_pull | sda_oe);
   assign reg_rdata = {3'b101, reg_ptr};
   assign mem_rdata = mem_ptr[7:0] ^ 8'h3c;

   always #2 core_clk = ~core_clk;

   crrp_slave #(.MEM_AW(MAW)) dut (.core_clk(core_clk), .nrst(nrst),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .dev_sel(dev_sel), .reg_ptr(reg_ptr), .reg_rdata(reg_rdata),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .mem_ptr(mem_ptr),
      .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .wr_addr(wr_addr), .wr_data(wr_data));

   crrp_i2c_master m (.core_clk(core_clk), .sda(sda), .scl(scl),
      .sda_pull(sda_pull));

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a hung bus would otherwise run forever
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] adr(input logic [3:0] id,
                                      input logic [1:0] s, input logic rd);
      return {id, 1'b0, s, rd};
   endfunction

   task automatic open_t(input logic [7:0] a, output logic ack);
      logic [7:0] q;
      m.start();
      m.xbyte(a, 1'b1, q, ack);
   endtask

   // write-style address load; acks = {slave address, last address byte}
   task automatic ld(input logic [7:0] sa, input int nb,
                     input logic [15:0] a, output logic [1:0] acks);
      logic [7:0] q;
      open_t(sa, acks[1]);
      if (nb == 2) begin
         m.xbyte(a[15:8], 1'b1, q, acks[0]);
      end
      m.xbyte(a[7:0], 1'b1, q, acks[0]);
      m.stop();
   endtask

   // current-address read of n bytes, last one not acknowledged
   task automatic rd_chk(input logic [3:0] id, input int n,
                         input logic [14:0] p0);
      logic ack;
      logic [7:0] q;
      logic [14:0] p;
      int r0;
      int m0;
      p = p0;
      r0 = n_rrd;
      m0 = n_mrd;
      open_t(adr(id, SEL, 1'b1), ack);
      chk(ack, 0);
      for (int i = 0; i < n; i++) begin
         m.xbyte(8'hff, i == n - 1, q, ack);
         chk(q, (id == 4'hd) ? {3'b101, p[4:0]} : p[7:0] ^ 8'h3c);
         p = (id == 4'hd && p == 15'h18) ? 15'h0 : p + 15'h1;
      end
      m.stop();
      chk((id == 4'hd) ? reg_ptr : mem_ptr, p);
      chk((id == 4'hd) ? n_rrd - r0 : n_mrd - m0, n);
      chk((id == 4'hd) ? n_mrd - m0 : n_rrd - r0, 0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(reg_ptr, 0);
      chk(mem_ptr, 0);
      chk(sda_oe, 0);
      chk(sda_o, 0);
   endtask

   // read across the top register and wrap
   task automatic t_reg();
      logic [1:0] a;
      ld(adr(4'hd, SEL, 1'b0), 1, 16'h0016, a);
      chk(a, 0);
      rd_chk(4'hd, 4, 15'h16);
   endtask

   // memory read interrupted by a register read, then resumed
   task automatic t_mem();
      logic [1:0] a;
      ld(adr(4'ha, SEL, 1'b0), 2, 16'h7ffe, a);
      chk(a, 0);
      chk(reg_ptr, 1);
      rd_chk(4'ha, 3, 15'h7ffe);
      rd_chk(4'hd, 1, 15'h1);
      chk(mem_ptr, 1);
      rd_chk(4'ha, 1, 15'h1);
      chk(reg_ptr, 2);
   endtask

   task automatic t_refuse();
      logic [1:0] a;
      logic k;
      ld(adr(4'hd, SEL, 1'b0), 1, 16'h0019, a);
      chk(a, 2'b01);
      chk(reg_ptr, 2);
      ld(adr(4'hd, SEL, 1'b0), 1, 16'h00e3, a);
      chk(a, 0);
      chk(reg_ptr, 3);
      open_t(adr(4'hd, ~SEL, 1'b1), k);
      m.stop();
      chk(k, 1);
      open_t(adr(4'hb, SEL, 1'b1), k);
      m.stop();
      chk(k, 1);
      chk(reg_ptr, 3);
      chk(mem_ptr, 2);
   endtask

   // one register write and one memory write, each with its address
   task automatic t_wr();
      logic [7:0] q;
      logic k;
      int r0;
      int m0;
      r0 = n_rwr;
      m0 = n_mwr;
      open_t(adr(4'hd, SEL, 1'b0), k);
      m.xbyte(8'h05, 1'b1, q, k);
      m.xbyte(8'h5a, 1'b1, q, k);
      m.stop();
      chk(k, 0);
      chk(n_rwr - r0, 1);
      chk(n_mwr - m0, 0);
      chk(wr_addr, 15'h0005);
      chk(wr_data, 8'h5a);
      chk(reg_ptr, 6);
      open_t(adr(4'ha, SEL, 1'b0), k);
      m.xbyte(8'h12, 1'b1, q, k);
      m.xbyte(8'h34, 1'b1, q, k);
      m.xbyte(8'ha5, 1'b1, q, k);
      m.stop();
      chk(k, 0);
      chk(n_mwr - m0, 1);
      chk(n_rwr - r0, 1);
      chk(wr_addr, 15'h1234);
      chk(wr_data, 8'ha5);
      chk(mem_ptr, 15'h1235);
      chk(reg_ptr, 6);
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      repeat (10) @(posedge core_clk);
      #1;
      t_reset();
      t_reg();
      t_mem();
      t_refuse();
      t_wr();
      conclude();
   end
endmodule
